/* hw/sre_receiver.sv */
// serial receiver with error flags, standby wakeup and ahb-lite registers
//
// Design decisions made here: the address map and the AHB-Lite slave port.
module sre_receiver (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // serial line
    input wire logic receive_line_pin,
    // system state
    input wire logic wait_mode,
    input wire logic stop_mode,
    input wire logic debug_break,
    // requests
    output logic rx_irq,
    output logic err_irq,
    output logic wait_wakeup
);
    typedef struct packed {
        logic hrdy;
        logic hresp;
        logic [31:0] hrdata;
        logic wr_pend;
        logic [4:0] waddr;
        logic [7:0] ctl1;
        logic [7:0] ctl2;
        logic [7:0] ctl3;
        logic [15:0] baud;
        logic [15:0] div;
        logic tick;
        logic s1;
        logic s2;
        logic s3;
        logic line;
        logic lp;
        sre_pkg::sre_rx_state_e state;
        logic [4:0] rt;
        logic [3:0] bitn;
        logic [8:0] sh;
        logic [1:0] smp;
        logic nz;
        logic lastbit;
        logic [1:0] ones;
        logic [7:0] idle_cnt;
        logic idle_arm;
        logic [8:0] data;
        logic rbf;
        logic idle_f;
        logic ovr;
        logic nf;
        logic fe;
        logic pe;
        logic clr_arm;
        logic rx_irq;
        logic err_irq;
        logic wake;
    } sre_state_s;

    localparam sre_state_s ST_RST = '{
        hrdy: 1'b1,
        ctl1: sre_pkg::RST_CTRL,
        ctl2: sre_pkg::RST_CTRL,
        ctl3: sre_pkg::RST_CTRL,
        baud: sre_pkg::RST_BAUD,
        s1: 1'b1,
        s2: 1'b1,
        s3: 1'b1,
        line: 1'b1,
        lp: 1'b1,
        state: sre_pkg::RX_HUNT,
        default: '0
    };

    sre_state_s q;
    sre_state_s n;
    logic tk;
    logic nine;
    logic [2:0] sm;
    logic maj;
    logic dis;
    logic [4:0] cur;
    logic done;
    logic [8:0] cdat;
    logic pe_hit;
    logic [7:0] ilim;
    logic held;
    logic hit;
    logic acc;
    logic prot;
    logic [31:0] rdata;
    logic [5:0] flags;
    logic stby;

    always_comb begin
        n = q;
        done = 1'b0;
        rdata = 32'h0000_0000;
        nine = q.ctl1[sre_pkg::C1_NINE];
        stby = q.ctl2[sre_pkg::C2_STBY];
        // three-stage pin synchroniser; a level counts once stages two and three agree
        n.s1 = receive_line_pin;
        n.s2 = q.s1;
        n.s3 = q.s2;
        if (q.s2 == q.s3) begin
            n.line = q.s3;
        end
        // 16x oversample enable; frozen entirely in stop mode
        n.tick = 1'b0;
        if (!stop_mode) begin
            if (q.div == 16'h0000) begin
                n.div = q.baud;
                n.tick = 1'b1;
            end else begin
                n.div = q.div - 16'h0001;
            end
        end
        tk = q.tick && q.ctl1[sre_pkg::C1_RXEN];
        cur = q.rt + 5'h01;
        sm = {q.line, q.smp};
        maj = (sm[0] & sm[1]) | (sm[0] & sm[2]) | (sm[1] & sm[2]);
        dis = (|sm) && !(&sm);
        cdat = nine ? q.sh : {1'b0, q.sh[8:1]};
        pe_hit = q.ctl1[sre_pkg::C1_PEN] && ((^cdat) ^ q.ctl1[sre_pkg::C1_ODD]);
        // receive state machine, one step per oversample tick
        if (!q.ctl1[sre_pkg::C1_RXEN]) begin
            n.state = sre_pkg::RX_HUNT;
            n.ones = 2'h0;
        end else if (tk) begin
            n.lp = q.line;
            n.rt = cur;
            case (q.state)
                sre_pkg::RX_HUNT: begin
                    if (q.line) begin
                        if (q.ones != 2'h3) begin
                            n.ones = q.ones + 2'h1;
                        end
                    end else if (q.ones == 2'h3) begin
                        n.state = sre_pkg::RX_START;
                        n.rt = 5'h01;
                        n.nz = 1'b0;
                    end else begin
                        n.ones = 2'h0;
                    end
                end
                sre_pkg::RX_START: begin
                    if (cur == sre_pkg::RT_A) begin
                        n.smp[0] = q.line;
                    end
                    if (cur == sre_pkg::RT_B) begin
                        n.smp[1] = q.line;
                    end
                    if (cur == sre_pkg::RT_C) begin
                        if (maj) begin
                            n.state = sre_pkg::RX_HUNT;
                            n.ones = 2'h0;
                        end else begin
                            n.nz = dis;
                        end
                    end
                    if (cur == sre_pkg::RT_BIT) begin
                        n.state = sre_pkg::RX_DATA;
                        n.rt = 5'h00;
                        n.bitn = 4'h0;
                    end
                end
                sre_pkg::RX_DATA: begin
                    if (cur == sre_pkg::RT_S8) begin
                        n.smp[0] = q.line;
                    end
                    if (cur == sre_pkg::RT_S9) begin
                        n.smp[1] = q.line;
                    end
                    if (cur == sre_pkg::RT_S10) begin
                        n.sh = {maj, q.sh[8:1]};
                        n.lastbit = maj;
                        n.nz = q.nz | dis;
                    end
                    // a valid 1-to-0 edge after the samples starts the next bit here
                    if (cur == sre_pkg::RT_BIT
                        || (cur > sre_pkg::RT_S10 && q.lastbit && q.lp && !q.line)) begin
                        n.rt = (cur == sre_pkg::RT_BIT) ? 5'h00 : 5'h01;
                        n.bitn = q.bitn + 4'h1;
                        if (q.bitn == (nine ? sre_pkg::LAST_B9 : sre_pkg::LAST_B8)) begin
                            n.state = sre_pkg::RX_STOP;
                        end
                    end
                end
                sre_pkg::RX_STOP: begin
                    if (cur == sre_pkg::RT_S8) begin
                        n.smp[0] = q.line;
                    end
                    if (cur == sre_pkg::RT_S9) begin
                        n.smp[1] = q.line;
                    end
                    if (cur == sre_pkg::RT_S10) begin
                        done = 1'b1;
                        n.state = sre_pkg::RX_HUNT;
                        n.ones = maj ? 2'h3 : 2'h0;
                    end
                end
                default: begin
                    n.state = sre_pkg::RX_HUNT;
                end
            endcase
        end
        // idle detection counts ticks of a steady high line
        ilim = {(nine ? sre_pkg::IDLE_B9 : sre_pkg::IDLE_B8), 4'h0};
        held = q.ctl1[sre_pkg::C1_IDLE_COUNT_START_SELECT] && q.state != sre_pkg::RX_HUNT;
        hit = tk && q.line && !held && q.idle_arm && q.idle_cnt == ilim - 8'h01;
        if (tk) begin
            if (!q.line) begin
                n.idle_cnt = 8'h00;
                n.idle_arm = 1'b1;
            end else if (held) begin
                n.idle_cnt = 8'h00;
            end else if (q.idle_cnt != ilim) begin
                n.idle_cnt = q.idle_cnt + 8'h01;
            end
        end
        if (hit) begin
            n.idle_arm = 1'b0;
        end
        // bus address phase; registers are shut off while waiting
        n.hrdy = 1'b1;
        n.hresp = 1'b0;
        acc = hsel && htrans[1] && hready && !wait_mode;
        prot = debug_break && !q.ctl3[sre_pkg::C3_BCE];
        flags = {q.rbf, q.idle_f, q.ovr, q.nf, q.fe, q.pe};
        n.wr_pend = acc && hwrite;
        n.waddr = haddr[4:0];
        if (acc && !hwrite) begin
            case (haddr[4:0])
                sre_pkg::A_CTRL1: rdata = {24'h000000, q.ctl1};
                sre_pkg::A_CTRL2: rdata = {24'h000000, q.ctl2};
                sre_pkg::A_CTRL3: rdata = {24'h000000, q.ctl3};
                sre_pkg::A_STAT: rdata = {26'h0000000, flags};
                sre_pkg::A_DATA: rdata = {23'h000000, q.data};
                sre_pkg::A_BAUD: rdata = {16'h0000, q.baud};
                default: rdata = 32'h0000_0000;
            endcase
            // two-step clear: status read with a flag up, then data read
            if (!prot && haddr[4:0] == sre_pkg::A_STAT && |flags) begin
                n.clr_arm = 1'b1;
            end
            if (!prot && haddr[4:0] == sre_pkg::A_DATA && q.clr_arm) begin
                n.clr_arm = 1'b0;
                n.rbf = 1'b0;
                n.idle_f = 1'b0;
                n.ovr = 1'b0;
                n.nf = 1'b0;
                n.fe = 1'b0;
                n.pe = 1'b0;
            end
        end
        n.hrdata = rdata;
        if (q.wr_pend) begin
            case (q.waddr)
                sre_pkg::A_CTRL1: n.ctl1 = hwdata[7:0];
                sre_pkg::A_CTRL2: n.ctl2 = hwdata[7:0];
                sre_pkg::A_CTRL3: n.ctl3 = hwdata[7:0];
                sre_pkg::A_BAUD: n.baud = hwdata[15:0];
                default: n.baud = n.baud;
            endcase
        end
        // hardware sets come last so they win over a same-cycle clear
        if (done && (!stby || (q.ctl1[sre_pkg::C1_WAKE] && q.sh[8]))) begin
            if (stby) begin
                n.ctl2[sre_pkg::C2_STBY] = 1'b0;
            end
            if (q.rbf) begin
                n.ovr = 1'b1;
            end else begin
                n.data = cdat;
                n.rbf = 1'b1;
                n.fe = !maj;
                n.nf = q.nz | dis;
                n.pe = pe_hit;
            end
        end
        // idle-line wakeup also fires at once if the line is already idle
        if (stby && !q.ctl1[sre_pkg::C1_WAKE] && q.line && q.idle_cnt == ilim) begin
            n.ctl2[sre_pkg::C2_STBY] = 1'b0;
        end else if (hit && !stby) begin
            n.idle_f = 1'b1;
        end
        // requests are held low in standby and in stop mode
        n.rx_irq = !stby && !stop_mode
            && ((q.rbf && q.ctl2[sre_pkg::C2_RIE]) || (q.idle_f && q.ctl2[sre_pkg::C2_IIE]));
        n.err_irq = !stby && !stop_mode
            && ((q.ovr && q.ctl3[sre_pkg::C3_OIE]) || (q.nf && q.ctl3[sre_pkg::C3_NIE])
            || (q.fe && q.ctl3[sre_pkg::C3_FIE]) || (q.pe && q.ctl3[sre_pkg::C3_PIE]));
        n.wake = wait_mode && (q.rx_irq || q.err_irq);
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            q <= ST_RST;
        end else begin
            q <= n;
        end
    end

    assign hrdata = q.hrdata;
    assign hreadyout = q.hrdy;
    assign hresp = q.hresp;
    assign rx_irq = q.rx_irq;
    assign err_irq = q.err_irq;
    assign wait_wakeup = q.wake;

    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    sequence s_char_end;
        done && !q.ctl2[sre_pkg::C2_STBY];
    endsequence
    sequence s_addr_mark;
        done && q.ctl2[sre_pkg::C2_STBY] && q.ctl1[sre_pkg::C1_WAKE] && q.sh[8];
    endsequence

    chk_fe_with_full: assert property ($rose(q.fe) |-> $rose(q.rbf))
        else $error("framing flag rose without buffer full");
    chk_stop_frame: assert property (s_char_end ##0 (!q.rbf && !maj) |=> q.fe)
        else $error("missing stop bit did not set framing flag");
    chk_stop_noise: assert property (s_char_end ##0 (!q.rbf && dis) |=> q.nf && q.rbf)
        else $error("disagreeing stop samples did not set noise");
    chk_standby_quiet: assert property (q.ctl2[sre_pkg::C2_STBY] |=> !q.rx_irq && !q.err_irq)
        else $error("interrupt raised in standby");
    chk_addr_wake: assert property (s_addr_mark |=> !q.ctl2[sre_pkg::C2_STBY] ##0 q.rbf)
        else $error("address mark did not wake receiver");
    chk_overrun_keep: assert property (s_char_end ##0 q.rbf
        |=> q.ovr && q.data == $past(q.data))
        else $error("overrun lost buffered character");
    chk_full_irq: assert property (q.rbf && q.ctl2[sre_pkg::C2_RIE] && !q.ctl2[sre_pkg::C2_STBY]
        && !stop_mode |=> q.rx_irq)
        else $error("buffer full did not request interrupt");
    chk_stop_mode: assert property (stop_mode |=> !q.rx_irq && !q.err_irq ##0 !q.tick)
        else $error("activity in stop mode");
    chk_wait_wake: assert property (wait_mode && (q.rx_irq || q.err_irq) |=> q.wake)
        else $error("enabled request did not end wait");
    chk_brk_protect: assert property (debug_break && !q.ctl3[sre_pkg::C3_BCE]
        |=> !$fell(q.rbf) && !$fell(q.fe))
        else $error("flag cleared during protected break");
    chk_fe_irq: assert property (q.fe && q.ctl3[sre_pkg::C3_FIE] && !q.ctl2[sre_pkg::C2_STBY]
        && !stop_mode |=> q.err_irq)
        else $error("framing flag did not request error interrupt");
endmodule

/* shared/sre_pkg.sv */
// constants and types shared by the serial receiver block
package sre_pkg;
    // register byte offsets
    localparam logic [4:0] A_CTRL1 = 5'h00;
    localparam logic [4:0] A_CTRL2 = 5'h04;
    localparam logic [4:0] A_CTRL3 = 5'h08;
    localparam logic [4:0] A_STAT = 5'h0C;
    localparam logic [4:0] A_DATA = 5'h10;
    localparam logic [4:0] A_BAUD = 5'h14;
    // serial_control_one fields
    localparam int C1_RXEN = 6;
    localparam int C1_NINE = 4;
    localparam int C1_WAKE = 3;
    localparam int C1_IDLE_COUNT_START_SELECT = 2;
    localparam int C1_PEN = 1;
    localparam int C1_ODD = 0;
    // serial_control_two fields
    localparam int C2_RIE = 5;
    localparam int C2_IIE = 4;
    localparam int C2_STBY = 1;
    // serial_control_three fields
    localparam int C3_BCE = 7;
    localparam int C3_OIE = 3;
    localparam int C3_NIE = 2;
    localparam int C3_FIE = 1;
    localparam int C3_PIE = 0;
    // serial_status_one fields
    localparam int S_RBF = 5;
    localparam int S_IDLE = 4;
    localparam int S_OVR = 3;
    localparam int S_NF = 2;
    localparam int S_FE = 1;
    localparam int S_PE = 0;
    // reset values
    localparam logic [7:0] RST_CTRL = 8'h00;
    localparam logic [15:0] RST_BAUD = 16'h0009;
    // oversample positions within one bit time
    localparam logic [4:0] RT_A = 5'h03;
    localparam logic [4:0] RT_B = 5'h05;
    localparam logic [4:0] RT_C = 5'h07;
    localparam logic [4:0] RT_S8 = 5'h08;
    localparam logic [4:0] RT_S9 = 5'h09;
    localparam logic [4:0] RT_S10 = 5'h0A;
    localparam logic [4:0] RT_BIT = 5'h10;
    // idle character length in bits, 8-bit and 9-bit formats
    localparam logic [3:0] IDLE_B8 = 4'hA;
    localparam logic [3:0] IDLE_B9 = 4'hB;
    // last data bit index, 8-bit and 9-bit formats
    localparam logic [3:0] LAST_B8 = 4'h7;
    localparam logic [3:0] LAST_B9 = 4'h8;
    typedef enum logic [1:0] {
        RX_HUNT = 2'b00,
        RX_START = 2'b01,
        RX_DATA = 2'b10,
        RX_STOP = 2'b11
    } sre_rx_state_e;
endpackage

/* test/sre_tx_model.sv */
// far-end asynchronous transmitter model driving the receive line
module sre_tx_model #(
    parameter int BIT_CLKS = 16
) (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // character request
    input wire logic send,
    input wire logic [10:0] frame,
    input wire logic [3:0] nbits,
    input wire logic [4:0] stop_dly,
    // line side
    output logic line,
    output logic busy
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [10:0] sh_q;
    logic [3:0] left_q;
    logic [7:0] cnt_q;
    logic [4:0] ext_q;
    // bits leave lsb first after a low start bit; stop_dly stretches the bit before
    // the stop bit so the stop edge can be slid across the receiver's sample points
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            line <= 1'h1;
            busy <= 1'h0;
            sh_q <= 11'h7FF;
            left_q <= 4'h0;
            cnt_q <= 8'h00;
            ext_q <= 5'h00;
        end else if (!busy) begin
            if (send) begin
                line <= 1'h0;
                busy <= 1'h1;
                sh_q <= frame;
                left_q <= nbits;
                ext_q <= stop_dly;
                cnt_q <= 8'(BIT_CLKS - 1);
            end
        end else if (cnt_q != 8'h00) begin
            cnt_q <= cnt_q - 8'h01;
        end else if (left_q == 4'h1 && ext_q != 5'h00) begin
            ext_q <= ext_q - 5'h01;
        end else if (left_q == 4'h0) begin
            // released line returns to its pull-up level
            busy <= 1'h0;
            line <= 1'h1;
        end else begin
            line <= sh_q[0];
            sh_q <= sh_q >> 1;
            left_q <= left_q - 4'h1;
            cnt_q <= 8'(BIT_CLKS - 1);
        end
    end
endmodule

/* test/tb_top.sv */
// self-checking bench for the serial receiver block
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic hclk = 1'h0;
    logic hresetn = 1'h0;
    logic hsel = 1'h0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'h0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic [31:0] rd;
    logic hready;
    logic hreadyout;
    logic hresp;
    logic line;
    logic wait_mode = 1'h0;
    logic stop_mode = 1'h0;
    logic debug_break = 1'h0;
    logic rx_irq;
    logic err_irq;
    logic wait_wakeup;
    logic send = 1'h0;
    logic [10:0] frame = 11'h7FF;
    logic [3:0] nbits = 4'h9;
    logic [4:0] stop_dly = 5'h00;
    logic busy;
    logic busy_f;
    logic line_f;
    logic rx_pin;
    logic fast = 1'h0;
    logic nine = 1'h0;
    logic rie = 1'h0;
    logic [7:0] c3 = 8'h00;
    logic [8:0] d = 9'h000;
    logic [4:0] dly_t [4] = '{5'h00, 5'h08, 5'h09, 5'h0A};
    integer seed = 32'h0577;
    int err_count = 0;
    int cmp_count = 0;
    int i;
    assign hready = hreadyout;
    always #5 hclk = ~hclk;
    sre_receiver sre_receiver_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .receive_line_pin(rx_pin), .wait_mode(wait_mode), .stop_mode(stop_mode),
        .debug_break(debug_break), .rx_irq(rx_irq), .err_irq(err_irq),
        .wait_wakeup(wait_wakeup));
    sre_tx_model sre_tx_model_inst (.hclk(hclk), .hresetn(hresetn), .send(send && !fast),
        .frame(frame), .nbits(nbits), .stop_dly(stop_dly), .line(line), .busy(busy));
    // one clock per bit fast: without resync the late data bits would be misread
    sre_tx_model #(.BIT_CLKS(15)) sre_tx_model_fast_inst (.hclk(hclk), .hresetn(hresetn),
        .send(send && fast), .frame(frame), .nbits(nbits), .stop_dly(stop_dly),
        .line(line_f), .busy(busy_f));
    assign rx_pin = fast ? line_f : line;
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    function automatic logic [31:0] st(input logic f, o, n, e, p);
        st = 32'h0;
        st[sre_pkg::S_RBF] = f;
        st[sre_pkg::S_OVR] = o;
        st[sre_pkg::S_NF] = n;
        st[sre_pkg::S_FE] = e;
        st[sre_pkg::S_PE] = p;
    endfunction
    function automatic logic errx(input logic [31:0] s);
        errx = (s[sre_pkg::S_OVR] & c3[sre_pkg::C3_OIE]) | (s[sre_pkg::S_NF] & c3[sre_pkg::C3_NIE])
            | (s[sre_pkg::S_FE] & c3[sre_pkg::C3_FIE]) | (s[sre_pkg::S_PE] & c3[sre_pkg::C3_PIE]);
    endfunction
    function automatic logic [10:0] fr(input logic [8:0] v, input logic s);
        fr = nine ? {1'h1, s, v} : {2'h3, s, v[7:0]};
    endfunction
    // the slave never stretches, but the wait stays so a stall would still be honoured
    task automatic edge_rdy();
        int k;
        k = 0;
        @(posedge hclk);
        while (hready !== 1'h1 && k < 50) begin
            @(posedge hclk);
            k++;
        end
        check(k >= 50, 1'h0);
    endtask
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] wd);
        hsel <= 1'h1;
        haddr <= {27'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        edge_rdy();
        hsel <= 1'h0;
        htrans <= 2'h0;
        hwdata <= wd;
        edge_rdy();
        rd = hrdata;
        check(hresp, 1'h0);
    endtask
    task automatic wr(input logic [4:0] a, input logic [31:0] v);
        bus(1'h1, a, v);
    endtask
    task automatic rdc(input logic [4:0] a, input logic [31:0] e);
        bus(1'h0, a, 32'h0);
        check(rd, e);
    endtask
    // idle flag is masked: it may legally form in any long gap between characters
    task automatic rds(input logic [31:0] e);
        bus(1'h0, sre_pkg::A_STAT, 32'h0);
        check(rd & ~(32'h1 << sre_pkg::S_IDLE), e);
    endtask
    task automatic tx(input logic [8:0] v, input logic s, input logic [4:0] dl);
        int k;
        k = 0;
        frame <= fr(v, s);
        nbits <= nine ? 4'hA : 4'h9;
        stop_dly <= dl;
        send <= 1'h1;
        @(posedge hclk);
        send <= 1'h0;
        @(posedge hclk);
        while ((busy | busy_f) === 1'h1 && k < 400) begin
            @(posedge hclk);
            k++;
        end
        check(k >= 400, 1'h0);
        repeat (2) @(posedge hclk);
    endtask
    task automatic rx_chk(input logic [8:0] v, input logic s, input logic [4:0] dl,
                          input logic [31:0] e, input logic [8:0] ed);
        tx(v, s, dl);
        rds(e);
        check(rx_irq, rie);
        check(err_irq, errx(e));
        rdc(sre_pkg::A_DATA, {23'h0, ed});
        rds(32'h0);
    endtask
    initial begin
        #200us;
        err_count++;
        $display("CHECK FAILED at %0t: watchdog expired", $time);
        wrap_up();
    end
    initial begin
        repeat (12) @(posedge hclk);
        hresetn <= 1'h1;
        @(posedge hclk);
        rdc(sre_pkg::A_CTRL1, 32'h0);
        rdc(sre_pkg::A_CTRL2, 32'h0);
        rdc(sre_pkg::A_CTRL3, 32'h0);
        rdc(sre_pkg::A_BAUD, {16'h0, sre_pkg::RST_BAUD});
        rdc(sre_pkg::A_STAT, 32'h0);
        rdc(sre_pkg::A_DATA, 32'h0);
        rdc(5'h18, 32'h0);
        wr(sre_pkg::A_BAUD, 32'h0);
        rie = 1'h1;
        wr(sre_pkg::A_CTRL2, 32'h1 << sre_pkg::C2_RIE);
        for (i = 0; i < 8; i++) begin
            nine = i > 3;
            wr(sre_pkg::A_CTRL1, (32'h1 << sre_pkg::C1_RXEN) | (nine << sre_pkg::C1_NINE));
            d = 9'($random(seed));
            rx_chk(d, 1'h1, 5'h00, st(1, 0, 0, 0, 0), nine ? d : {1'h0, d[7:0]});
        end
        nine = 1'h0;
        wr(sre_pkg::A_CTRL1, 32'h1 << sre_pkg::C1_RXEN);
        fast <= 1'h1;
        rx_chk(9'h055, 1'h1, 5'h00, st(1, 0, 0, 0, 0), 9'h055);
        fast <= 1'h0;
        tx(9'h055, 1'h0, 5'h00);
        check(err_irq, 1'h0);
        c3 = 8'h0F;
        wr(sre_pkg::A_CTRL3, {24'h0, c3});
        repeat (2) @(posedge hclk);
        check(err_irq, 1'h1);
        rds(st(1, 0, 0, 1, 0));
        rdc(sre_pkg::A_DATA, 32'h55);
        rx_chk(9'h000, 1'h0, 5'h00, st(1, 0, 0, 1, 0), 9'h000);
        for (i = 0; i < 4; i++) begin
            rx_chk(9'h000, 1'h1, dly_t[i], st(1, 0, i == 1 || i == 2, i > 1, 0), 9'h000);
        end
        for (i = 0; i < 4; i++) begin
            wr(sre_pkg::A_CTRL1, (32'h1 << sre_pkg::C1_RXEN) | (32'h1 << sre_pkg::C1_PEN) | i[0]);
            d = 9'($random(seed)) & 9'h07F;
            d[7] = ^d[6:0] ^ i[0] ^ i[1];
            rx_chk(d, 1'h1, 5'h00, st(1, 0, 0, 0, i[1]), d);
        end
        wr(sre_pkg::A_CTRL1, 32'h1 << sre_pkg::C1_RXEN);
        d = 9'($random(seed)) & 9'h0FF;
        tx(d, 1'h1, 5'h00);
        tx(~d & 9'h0FF, 1'h1, 5'h00);
        rds(st(1, 1, 0, 0, 0));
        check(err_irq, 1'h1);
        rdc(sre_pkg::A_DATA, {23'h0, d});
        rds(32'h0);
        tx(d, 1'h1, 5'h00);
        wait_mode <= 1'h1;
        repeat (3) @(posedge hclk);
        check(wait_wakeup, 1'h1);
        rdc(sre_pkg::A_STAT, 32'h0);
        wr(sre_pkg::A_CTRL2, 32'h0);
        wait_mode <= 1'h0;
        stop_mode <= 1'h1;
        repeat (3) @(posedge hclk);
        check(rx_irq, 1'h0);
        stop_mode <= 1'h0;
        rdc(sre_pkg::A_CTRL2, 32'h1 << sre_pkg::C2_RIE);
        check(rx_irq, 1'h1);
        rds(st(1, 0, 0, 0, 0));
        debug_break <= 1'h1;
        rdc(sre_pkg::A_DATA, {23'h0, d});
        rds(st(1, 0, 0, 0, 0));
        debug_break <= 1'h0;
        rdc(sre_pkg::A_DATA, {23'h0, d});
        rds(32'h0);
        c3 = 8'h8F;
        wr(sre_pkg::A_CTRL3, {24'h0, c3});
        tx(d, 1'h1, 5'h00);
        debug_break <= 1'h1;
        rds(st(1, 0, 0, 0, 0));
        rdc(sre_pkg::A_DATA, {23'h0, d});
        debug_break <= 1'h0;
        rds(32'h0);
        wr(sre_pkg::A_CTRL1, (32'h1 << sre_pkg::C1_RXEN) | (32'h1 << sre_pkg::C1_WAKE));
        wr(sre_pkg::A_CTRL2, (32'h1 << sre_pkg::C2_RIE) | (32'h1 << sre_pkg::C2_STBY));
        tx(9'h055, 1'h0, 5'h00);
        rds(32'h0);
        check(rx_irq | err_irq, 1'h0);
        rdc(sre_pkg::A_CTRL2, (32'h1 << sre_pkg::C2_RIE) | (32'h1 << sre_pkg::C2_STBY));
        d = (9'($random(seed)) & 9'h0FF) | 9'h080;
        tx(d, 1'h1, 5'h00);
        rds(st(1, 0, 0, 0, 0));
        rdc(sre_pkg::A_CTRL2, 32'h1 << sre_pkg::C2_RIE);
        rdc(sre_pkg::A_DATA, {23'h0, d});
        wr(sre_pkg::A_CTRL1, 32'h1 << sre_pkg::C1_RXEN);
        wr(sre_pkg::A_CTRL2, 32'h1 << sre_pkg::C2_IIE);
        d = 9'($random(seed)) & 9'h07F;
        tx(d, 1'h1, 5'h00);
        rdc(sre_pkg::A_STAT, st(1, 0, 0, 0, 0));
        rdc(sre_pkg::A_DATA, {23'h0, d});
        repeat (170) @(posedge hclk);
        rdc(sre_pkg::A_STAT, 32'h1 << sre_pkg::S_IDLE);
        check(rx_irq, 1'h1);
        bus(1'h0, sre_pkg::A_DATA, 32'h0);
        tx(d, 1'h1, 5'h00);
        rds(st(1, 0, 0, 0, 0));
        rdc(sre_pkg::A_DATA, {23'h0, d});
        wr(sre_pkg::A_CTRL2, (32'h1 << sre_pkg::C2_IIE) | (32'h1 << sre_pkg::C2_STBY));
        repeat (200) @(posedge hclk);
        rdc(sre_pkg::A_CTRL2, 32'h1 << sre_pkg::C2_IIE);
        rdc(sre_pkg::A_STAT, 32'h0);
        check(rx_irq, 1'h0);
        wr(sre_pkg::A_CTRL1, (32'h1 << sre_pkg::C1_RXEN) | (32'h1 << sre_pkg::C1_IDLE_COUNT_START_SELECT));
        tx(9'h0FF, 1'h1, 5'h00);
        repeat (40) @(posedge hclk);
        rdc(sre_pkg::A_STAT, st(1, 0, 0, 0, 0));
        rdc(sre_pkg::A_DATA, 32'hFF);
        repeat (170) @(posedge hclk);
        rdc(sre_pkg::A_STAT, 32'h1 << sre_pkg::S_IDLE);
        check(rx_irq, 1'h1);
        wr(sre_pkg::A_CTRL2, (32'h1 << sre_pkg::C2_IIE) | (32'h1 << sre_pkg::C2_STBY));
        repeat (2) @(posedge hclk);
        rdc(sre_pkg::A_CTRL2, 32'h1 << sre_pkg::C2_IIE);
        wrap_up();
    end
endmodule
